// File: common/lsgr_pkg.sv
// Shared constants and carriers for the link status and pin zero register slice
package lsgr_pkg;

    // Register offsets on the serial control bus
    localparam logic [7:0] LSGR_OFS_CRC_LOW    = 8'h0A;
    localparam logic [7:0] LSGR_OFS_CRC_HIGH   = 8'h0B;
    localparam logic [7:0] LSGR_OFS_STATUS     = 8'h0C;
    localparam logic [7:0] LSGR_OFS_PIN_CONFIG = 8'h0D;

    // Status register bit positions
    localparam int LSGR_ST_LINK_LOST = 4;
    localparam int LSGR_ST_SELFTEST  = 3;
    localparam int LSGR_ST_CLOCK     = 2;
    localparam int LSGR_ST_DES_ERROR = 1;
    localparam int LSGR_ST_LINK      = 0;

    // Pin configuration field positions
    localparam int LSGR_CFG_VALUE    = 3;
    localparam int LSGR_CFG_MODE_HI  = 2;
    localparam int LSGR_CFG_REV_LO   = 4;

    // Pin mode codes (low two bits decide inputs and high impedance)
    localparam logic [2:0] LSGR_MODE_GP_OUT      = 3'h1;
    localparam logic [2:0] LSGR_MODE_GP_IN       = 3'h3;
    localparam logic [2:0] LSGR_MODE_REMOTE_HOLD = 3'h5;
    localparam logic [2:0] LSGR_MODE_REMOTE_DEF  = 3'h7;
    localparam logic [1:0] LSGR_MODE_FUNC_IN_LO  = 2'h0;
    localparam logic [1:0] LSGR_MODE_HIGH_Z_LO   = 2'h2;

    // Reset values and counter limits
    localparam logic [2:0]  LSGR_MODE_RESET = 3'h0;
    localparam logic [15:0] LSGR_CNT_RESET  = 16'h0000;
    localparam logic [15:0] LSGR_CNT_MAX    = 16'hFFFF;
    localparam logic [15:0] LSGR_CNT_ONE    = 16'h0001;
    localparam logic [7:0]  LSGR_UNMAPPED   = 8'h00;

    // Number of link ports
    localparam int LSGR_PORTS = 2;

    // Pin configuration for one port
    typedef struct packed {
        logic       value;
        logic [2:0] mode;
    } lsgr_pcfg_s;

    // Per-port link events from the back channel
    typedef struct packed {
        logic link_detect;   // Level: cable link present
        logic crc_error;     // Pulse: back-channel CRC error, normal traffic
        logic selftest_crc;  // Pulse: back-channel CRC error during self-test
        logic selftest_go;   // Pulse: self-test restarted
        logic remote_pin;    // Level: remote_side_pin_zero value received
    } lsgr_link_s;

    // Register access port
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } lsgr_req_s;

endpackage

// File: logic/lsgr_regs.sv
// Functional notes
// - Upper count byte readable, cleared by reset bit
// - Link-lost bit sticky until CRC reset
// - Self-test CRC flag; cleared by loss, restart, reset
// - Bit 2 shows input clock presence
// - Normal CRC flag; cleared by loss or reset
// - Bit 0 shows cable link presence
// - Port select shows second port's counts, status
// - Local value driven in output mode, and in 111 on link loss
// - Codes x00 input, x10 high impedance
// - 001 output, 011 input
// - 101 remote value, held on link loss
// - 111 remote value, local value on loss
// - Port select steers pin fields to second port
// - Lower count byte; 16-bit count, same clear
`timescale 1ns/1ps
module lsgr_regs #(
    parameter logic [3:0] REVISION_ID = 4'h1  // Arbitrary revision value
) (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    // Register access
    input  wire lsgr_pkg::lsgr_req_s    req,
    output logic [7:0]                  rdata,
    // Neighbouring control bits
    input  wire logic                   crc_error_reset,
    input  wire logic                   second_port_select,
    // Status sources
    input  wire logic                   input_clock_present,
    input  wire lsgr_pkg::lsgr_link_s   link0,
    input  wire lsgr_pkg::lsgr_link_s   link1,
    // Local general_pin_zero drive
    output logic                        pin_out,
    output logic                        pin_oe,
    // Second port's pin configuration, sent over the link
    output lsgr_pkg::lsgr_pcfg_s        remote_cfg
);
    import lsgr_pkg::*;

    // Complete state of the slice
    // Everything lives in one struct, so reset and registering
    // stay in a single place and no field can be forgotten
    typedef struct packed {
        logic [LSGR_PORTS-1:0][15:0] cnt;        // CRC error counts
        logic [LSGR_PORTS-1:0]       lost;       // Sticky link lost
        logic [LSGR_PORTS-1:0]       st_err;     // Self-test CRC flag
        logic [LSGR_PORTS-1:0]       des_err;    // Normal CRC flag
        logic [LSGR_PORTS-1:0]       link_prev;  // Link level one cycle ago
        logic [LSGR_PORTS-1:0]       link;       // Registered link level
        logic                        clk_ok;     // Registered clock detect
        lsgr_pcfg_s [LSGR_PORTS-1:0] cfg;        // Pin configs per port
        logic                        hold;       // Last remote value seen
        logic                        pin_out;    // Pin level
        logic                        pin_oe;     // Pin enable
        logic [7:0]                  rdata;      // Read data
    } lsgr_state_s;

    // Registered state and the value it takes at the next edge
    lsgr_state_s  st_q;   // Registered state
    lsgr_state_s  st_d;   // Next state
    lsgr_link_s   lk [LSGR_PORTS];  // Port inputs as an array

    // Ports as an array so that the per-port loop can index them
    assign lk[0] = link0;
    assign lk[1] = link1;

    // Pin mode decode: does this mode drive the pin
    // Only plain output and the two remote modes enable the driver;
    // every x00, x10 and 011 code leaves the pin undriven
    function automatic logic drives(input logic [2:0] mode);
        drives = (mode == LSGR_MODE_GP_OUT) ||       // Local output
                 (mode == LSGR_MODE_REMOTE_HOLD) ||  // Remote, hold on loss
                 (mode == LSGR_MODE_REMOTE_DEF);     // Remote, default on loss
    endfunction

    // Next-state logic
    // Every field starts from its registered value; each event or
    // write below overrides only the fields that it owns
    always_comb begin
        logic       sel;   // Port whose fields software sees
        logic       loss;  // Registered link just fell on this port
        logic       live;  // Port 0 link level as it arrives
        lsgr_pcfg_s lc;    // Local pin configuration
        sel  = second_port_select;
        loss = 1'b0;
        live = lk[0].link_detect;
        lc   = st_q.cfg[0];
        st_d = st_q;

        // Clock detect is a level, registered once
        st_d.clk_ok = input_clock_present;

        // Per-port counters and flags, set wins over clear
        // Both ports run the same logic; only the read mux and the
        // config write pick one of them by the port select
        for (int p = 0; p < LSGR_PORTS; p++) begin
            // Link level and its last sample feed the fall detector
            st_d.link[p]      = lk[p].link_detect;
            st_d.link_prev[p] = st_q.link[p];
            // Loss is a one-cycle event when the registered level falls
            loss = st_q.link_prev[p] && !st_q.link[p];
            // Counter: clear then count, event kept
            if (crc_error_reset) begin
                // An error in the clearing cycle is counted, not dropped
                st_d.cnt[p] = lk[p].crc_error ? LSGR_CNT_ONE : LSGR_CNT_RESET;
            end else if (lk[p].crc_error && st_q.cnt[p] != LSGR_CNT_MAX) begin
                // Saturate so that a full count never wraps back to zero
                st_d.cnt[p] = 16'(st_q.cnt[p] + LSGR_CNT_ONE);
            end
            // Link lost sticky
            if (loss) begin
                // Loss wins over a clear in the same cycle
                st_d.lost[p] = 1'b1;
            end else if (crc_error_reset) begin
                // Software acknowledges the loss
                st_d.lost[p] = 1'b0;
            end
            // Self-test CRC flag
            if (lk[p].selftest_crc) begin
                // Error seen while self-test runs
                st_d.st_err[p] = 1'b1;
            end else if (loss || lk[p].selftest_go || crc_error_reset) begin
                // Loss, restart or software clear
                st_d.st_err[p] = 1'b0;
            end
            // Normal CRC flag
            if (lk[p].crc_error) begin
                // Error in normal traffic
                st_d.des_err[p] = 1'b1;
            end else if (loss || crc_error_reset) begin
                // Loss or software clear
                st_d.des_err[p] = 1'b0;
            end
        end

        // Pin config write to the selected port
        // Only the low nibble is writable; the top nibble is the revision
        if (req.wr && req.addr == LSGR_OFS_PIN_CONFIG) begin
            st_d.cfg[sel] = req.wdata[LSGR_CFG_VALUE:0];
        end

        // Remember remote value while link is up
        // Gated by the live level: once the link drops, the received
        // value is no longer trustworthy and must not overwrite the hold
        if (live) begin
            st_d.hold = lk[0].remote_pin;
        end

        // Local pin drive; port 1 settings never touch this pin
        // Remote modes follow the live link level, so the pin never
        // shows a value that arrived after the link went away
        st_d.pin_oe = drives(lc.mode);
        case (lc.mode)
            // Plain output of the stored value
            LSGR_MODE_GP_OUT: begin
                st_d.pin_out = lc.value;
            end
            // Remote value, last good value once the link is gone
            LSGR_MODE_REMOTE_HOLD: begin
                st_d.pin_out = live ? lk[0].remote_pin : st_q.hold;
            end
            // Remote value, stored local value once the link is gone
            LSGR_MODE_REMOTE_DEF: begin
                st_d.pin_out = live ? lk[0].remote_pin : lc.value;
            end
            // Inputs and high impedance leave the level low
            default: begin
                st_d.pin_out = 1'b0;
            end
        endcase

        // Read mux for the selected port
        // Data is registered, so it follows the address by one cycle;
        // the two count bytes are not latched together
        case (req.addr)
            // Low count byte
            LSGR_OFS_CRC_LOW: begin
                st_d.rdata = st_q.cnt[sel][7:0];
            end
            // High count byte
            LSGR_OFS_CRC_HIGH: begin
                st_d.rdata = st_q.cnt[sel][15:8];
            end
            // Status: per-port flags plus the shared clock detect
            LSGR_OFS_STATUS: begin
                st_d.rdata = LSGR_UNMAPPED;
                st_d.rdata[LSGR_ST_LINK_LOST] = st_q.lost[sel];
                st_d.rdata[LSGR_ST_SELFTEST]  = st_q.st_err[sel];
                st_d.rdata[LSGR_ST_CLOCK]     = st_q.clk_ok;
                st_d.rdata[LSGR_ST_DES_ERROR] = st_q.des_err[sel];
                st_d.rdata[LSGR_ST_LINK]      = st_q.link[sel];
            end
            // Revision above the selected port's pin settings
            LSGR_OFS_PIN_CONFIG: begin
                st_d.rdata = {REVISION_ID, st_q.cfg[sel]};
            end
            // Anything else reads as zero
            default: begin
                st_d.rdata = LSGR_UNMAPPED;
            end
        endcase
    end

    // State register
    // Asynchronous reset clears every field, outputs included
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            // All flags, counts and pin settings back to zero
            st_q <= '0;
        end else begin
            // Take the next state on every edge
            st_q <= st_d;
        end
    end

    // Outputs straight from flops
    // No logic sits between the state register and any port
    assign rdata      = st_q.rdata;
    assign pin_out    = st_q.pin_out;
    assign pin_oe     = st_q.pin_oe;
    assign remote_cfg = st_q.cfg[1];

endmodule

// File: testbench/lsgr_link_model.sv
`timescale 1ns/1ps
module lsgr_link_model (
    // Clock
    input  wire logic            mclk,
    // Bench commands: link level, event pulses, pin value
    input  wire logic            up,
    input  wire logic [2:0]      ev,
    input  wire logic            rpin,
    // Events toward the slice
    output lsgr_pkg::lsgr_link_s link
);
    import lsgr_pkg::*;
    // Quiet until the first edge
    initial link = '0;
    // Events one cycle late; pin value flips while down
    always @(posedge mclk) begin
        link <= '{up, ev[0], ev[1], ev[2], up ? rpin : ~link.remote_pin};
    end
endmodule

// File: testbench/lsgr_regs_monitor.sv
`timescale 1ns/1ps
module lsgr_regs_monitor (
    // Clock and reset
    input wire logic                 mclk,
    input wire logic                 reset_n,
    // Watched ports
    input wire lsgr_pkg::lsgr_req_s  req,
    input wire logic [7:0]           rdata,
    input wire logic                 second_port_select,
    input wire logic                 pin_out,
    input wire logic                 pin_oe,
    input wire lsgr_pkg::lsgr_pcfg_s remote_cfg
);
    import lsgr_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Pin config writes, local and second port
    wire cw = req.wr && req.addr == LSGR_OFS_PIN_CONFIG;
    wire lw = cw && !second_port_select;
    property p_fin; lw && req.wdata[1:0] == 2'h0 ##1 !req.wr |=> !pin_oe; endproperty
    a_fin: assert property (p_fin) else $error("input mode drives");
    property p_hiz; lw && req.wdata[1:0] == 2'h2 ##1 !req.wr |=> !pin_oe; endproperty
    a_hiz: assert property (p_hiz) else $error("high-z mode drives");
    property p_gpin; lw && req.wdata[2:0] == 3'h3 ##1 !req.wr |=> !pin_oe; endproperty
    a_gpin: assert property (p_gpin) else $error("gp input drives");
    property p_hi; lw && req.wdata[3:0] == 4'h9 ##1 !req.wr |=> pin_oe && pin_out; endproperty
    a_hi: assert property (p_hi) else $error("output high lost");
    property p_lo; lw && req.wdata[3:0] == 4'h1 ##1 !req.wr |=> pin_oe && !pin_out; endproperty
    a_lo: assert property (p_lo) else $error("output low lost");
    property p_rcfg; cw && second_port_select |=> remote_cfg == $past(req.wdata[3:0]); endproperty
    a_rcfg: assert property (p_rcfg) else $error("remote cfg wrong");
    property p_rloc; cw && second_port_select ##1 !req.wr |=> $stable(pin_oe); endproperty
    a_rloc: assert property (p_rloc) else $error("local pin moved");
    property p_rst; $rose(reset_n) |-> rdata == 8'h00 && !pin_oe; endproperty
    a_rst: assert property (p_rst) else $error("not reset");
    // Main scenarios reached
    c_rcfg: cover property (cw && second_port_select);
    c_out: cover property (pin_oe && pin_out);
    c_lost: cover property (req.addr == LSGR_OFS_STATUS ##2 rdata[4]);
endmodule
bind lsgr_regs lsgr_regs_monitor u_lsgr_regs_monitor (.mclk, .reset_n, .req, .rdata,
    .second_port_select, .pin_out, .pin_oe, .remote_cfg);

// File: testbench/tb_lsgr_regs.sv
`timescale 1ns/1ps
module tb_lsgr_regs;
    import lsgr_pkg::*;
    logic mclk = 0, reset_n = 0, crst = 0, sel = 0, clk_ok = 0;
    logic [1:0] up = 0, rp = 0;
    logic [2:0] ev0 = 0, ev1 = 0;
    lsgr_req_s req = '0;
    logic [7:0] rdata;
    logic pin_out, pin_oe;
    lsgr_pcfg_s rcfg;
    lsgr_link_s l0, l1;
    int n_errors = 0, cmp_count = 0;
    // 100 MHz clock
    always #5 mclk = ~mclk;
    lsgr_regs #(.REVISION_ID(4'h5)) u_lsgr_regs (.mclk, .reset_n, .req, .rdata,
        .crc_error_reset(crst), .second_port_select(sel), .input_clock_present(clk_ok),
        .link0(l0), .link1(l1), .pin_out, .pin_oe, .remote_cfg(rcfg));
    lsgr_link_model u_lsgr_link_model (.mclk, .up(up[0]), .ev(ev0), .rpin(rp[0]), .link(l0));
    lsgr_link_model u_lsgr_link_model_b (.mclk, .up(up[1]), .ev(ev1), .rpin(rp[1]), .link(l1));
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input logic [7:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, exp);
        req <= '{a, 1'b0, 8'h00};
        tick(2);
        chk(rdata, exp);
    endtask
    task automatic wr(input logic [7:0] a, d);
        req <= '{a, 1'b1, d};
        tick(1);
        req.wr <= 1'b0;
        tick(3);
    endtask
    // One event pulse on a port: 0 crc, 1 self-test crc, 2 restart
    task automatic pulse(input int p, b);
        if (p) ev1[b] <= 1'b1;
        else ev0[b] <= 1'b1;
        tick(1);
        ev0 <= 3'h0;
        ev1 <= 3'h0;
        tick(2);
    endtask
    task automatic clr();
        crst <= 1'b1;
        tick(1);
        crst <= 1'b0;
        tick(3);
    endtask
    task automatic t_regs();
        rd(LSGR_OFS_CRC_HIGH, 8'h00);
        rd(LSGR_OFS_CRC_LOW, 8'h00);
        rd(LSGR_OFS_PIN_CONFIG, 8'h50);
        wr(LSGR_OFS_STATUS, 8'hFF);
        rd(LSGR_OFS_STATUS, 8'h00);
        rd(8'h20, 8'h00);
    endtask
    task automatic t_status();
        up[0] <= 1'b1;
        clk_ok <= 1'b1;
        tick(4);
        rd(LSGR_OFS_STATUS, 8'h05);
        repeat (3) pulse(0, 0);
        rd(LSGR_OFS_CRC_LOW, 8'h03);
        rd(LSGR_OFS_STATUS, 8'h07);
        pulse(0, 1);
        rd(LSGR_OFS_STATUS, 8'h0F);
        pulse(0, 2);
        rd(LSGR_OFS_STATUS, 8'h07);
        pulse(0, 1);
        clr();
        rd(LSGR_OFS_STATUS, 8'h05);
        rd(LSGR_OFS_CRC_LOW, 8'h00);
        repeat (256) pulse(0, 0);
        rd(LSGR_OFS_CRC_HIGH, 8'h01);
        pulse(0, 1);
        up[0] <= 1'b0;
        tick(4);
        rd(LSGR_OFS_STATUS, 8'h14);
        up[0] <= 1'b1;
        tick(4);
        rd(LSGR_OFS_STATUS, 8'h15);
        clr();
        rd(LSGR_OFS_CRC_HIGH, 8'h00);
    endtask
    task automatic t_port();
        up[1] <= 1'b1;
        sel <= 1'b1;
        pulse(1, 0);
        rd(LSGR_OFS_CRC_LOW, 8'h01);
        rd(LSGR_OFS_STATUS, 8'h07);
        wr(LSGR_OFS_PIN_CONFIG, 8'h09);
        chk({4'h0, rcfg}, 8'h09);
        chk({6'h0, pin_oe, pin_out}, 8'h00);
        rd(LSGR_OFS_PIN_CONFIG, 8'h59);
        sel <= 1'b0;
        rd(LSGR_OFS_CRC_LOW, 8'h00);
    endtask
    task automatic t_pin();
        logic oe;
        rp[0] <= 1'b1;
        for (int m = 0; m < 16; m++) begin
            wr(LSGR_OFS_PIN_CONFIG, 8'(m));
            oe = m[0] && m[2:0] != 3'h3;
            chk({pin_oe, pin_out}, {oe, oe && (m[2] || m[3])});
        end
        wr(LSGR_OFS_PIN_CONFIG, 8'h05);
        up[0] <= 1'b0;
        tick(4);
        chk({pin_oe, pin_out}, 8'h03);
        wr(LSGR_OFS_PIN_CONFIG, 8'h07);
        chk({pin_oe, pin_out}, 8'h02);
    endtask
    task automatic give_verdict();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard
    initial begin
        tick(20000);
        n_errors++;
        give_verdict();
    end
    // Main sequence
    initial begin
        tick(2);
        reset_n <= 1'b1;
        tick(1);
        t_regs();
        t_status();
        t_port();
        t_pin();
        give_verdict();
    end
endmodule
